// >>> sdw_byte_pair.sv
// current/previous byte pair of one task-file register
module sdw_byte_pair (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // host byte write: old current moves to previous
    input wire logic push,
    input wire logic [7:0] push_byte,
    // device load of both bytes
    input wire logic load,
    input wire logic [15:0] load_val,
    // read side
    input wire logic hob,
    output logic [15:0] value,
    output logic [7:0] rd_byte
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] cur_r;
    logic [7:0] prev_r;

    // device load wins; host pushes are locked out while busy anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_r <= sdw_pkg::BYTE_RST;
            prev_r <= sdw_pkg::BYTE_RST;
        end else if (load) begin
            cur_r <= load_val[7:0];
            prev_r <= load_val[15:8];
        end else if (push) begin
            prev_r <= cur_r;
            cur_r <= push_byte;
        end
    end

    // pair value and selector-picked byte
    assign value = {prev_r, cur_r};
    assign rd_byte = hob ? prev_r : cur_r;

endmodule : sdw_byte_pair

// >>> sdw_host_dma.sv
// host slave-dma channel model supplying sector words
module sdw_host_dma #(
    parameter logic [15:0] WORD0 = 16'h0000
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // channel setup from the bench
    input wire logic armed,
    input wire logic slow,
    // device side
    input wire logic dmarq,
    output logic dmack,
    output logic [15:0] dma_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word_r;
    logic phase_r;
    // released lines show the inverse so a stale word never looks good
    assign dma_wdata = dmack ? word_r : ~word_r;
    // acknowledge only once set up, and only when paced by the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmack <= 1'b0;
            phase_r <= 1'b0;
            word_r <= WORD0;
        end else begin
            dmack <= armed && dmarq && (!slow || phase_r);
            phase_r <= ~phase_r;
            if (dmarq && dmack) begin
                word_r <= word_r + 16'h0001;
            end
        end
    end
endmodule : sdw_host_dma

// >>> sdw_pkg.sv
// constants, register map and state type of the extended dma sector write block
package sdw_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // apb register byte offsets, one aligned word each
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_FEATURE = 8'h00;
    localparam logic [7:0] A_SECT_CNT = 8'h04;
    localparam logic [7:0] A_SECT_NUM = 8'h08;
    localparam logic [7:0] A_CYL_LOW = 8'h0c;
    localparam logic [7:0] A_CYL_HIGH = 8'h10;
    localparam logic [7:0] A_DEV_HEAD = 8'h14;
    localparam logic [7:0] A_CMD_STAT = 8'h18;
    localparam logic [7:0] A_ERROR = 8'h1c;
    localparam logic [7:0] A_DEV_CTL = 8'h20;
    localparam logic [7:0] A_IRQ_STAT = 8'h24;
    localparam logic [7:0] A_IRQ_MASK = 8'h28;

    ////////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [7:0] CMD_WRITE_DMA_EXT = 8'h35;

    // status register bit positions
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;

    // error register bit positions
    localparam int ER_CRC = 7;
    localparam int ER_IDN = 4;
    localparam int ER_ABT = 2;

    // device control: high-order byte selector
    localparam int DC_HOB = 7;

    // interrupt status and mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [7:0] ERROR_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
    localparam logic [16:0] CNT_ZERO_SECTORS = 17'h10000;
    localparam int SECTOR_WORDS_DFLT = 256;

    // command sequencer states
    typedef enum logic [1:0] {
        SDW_IDLE,
        SDW_XFER,
        SDW_COMMIT,
        SDW_DONE
    } sdw_state_t;

endpackage : sdw_pkg

// >>> sdw_props.sv
// port-level checks on the extended dma sector write block
module sdw_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [sdw_pkg::ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // dma channel and media port
    input wire logic dmarq,
    input wire logic dmack,
    input wire logic [15:0] dma_wdata,
    input wire logic link_crc_err,
    input wire logic med_wvalid,
    input wire logic [15:0] med_wdata,
    input wire logic med_req,
    input wire logic med_done,
    input wire logic med_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a word moves only where request and acknowledge meet
    wire logic take = dmarq && dmack;

    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("apb access not answered at once");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h28 |-> pslverr)
        else $error("unmapped access without slave error");
    // a crc error seen mid-sector ends the command: no request, no commit for two cycles after it
    crc_pause_a: assert property (dmarq ##1 (link_crc_err && !med_req)
        |=> (!dmarq && !med_req)[*2])
        else $error("transfer continued after link crc error");
    word_pass_a: assert property (take |=> med_wvalid && med_wdata == $past(dma_wdata))
        else $error("taken word not passed to media");
    no_extra_word_a: assert property (!take |=> !med_wvalid)
        else $error("media word without a dma take");
    commit_excl_a: assert property (med_req |-> !dmarq)
        else $error("dma request during media commit");
    commit_hold_a: assert property (med_req && !med_done |=> med_req)
        else $error("commit request dropped before done");
    fail_stop_a: assert property (med_req && med_done && med_fail |=> (!dmarq && !med_req)[*4])
        else $error("transfer continued after failed sector");

    // main scenarios reached
    cover property (take ##1 med_wvalid);
    cover property (med_req && med_done && med_fail);
    cover property (link_crc_err);
endmodule : sdw_props

bind sdw_write_dma_ext sdw_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready,
    .pslverr, .dmarq, .dmack, .dma_wdata, .link_crc_err, .med_wvalid, .med_wdata, .med_req,
    .med_done, .med_fail);

// >>> sdw_write_dma_ext.sv
// task-file command interpreter for the extended dma sector write
module sdw_write_dma_ext #(
    parameter int SECTOR_WORDS = sdw_pkg::SECTOR_WORDS_DFLT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sdw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // slave dma channel
    output logic dmarq,
    input wire logic dmack,
    input wire logic [15:0] dma_wdata,
    input wire logic link_crc_err,
    // media write port
    output logic med_wvalid,
    output logic [15:0] med_wdata,
    output logic med_req,
    output logic [47:0] med_lba,
    input wire logic med_done,
    input wire logic med_fail,
    // interrupt
    output logic irq
);

    localparam int WCNT_W = $clog2(SECTOR_WORDS);
    localparam logic [WCNT_W-1:0] LAST_WORD = WCNT_W'(SECTOR_WORDS - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    sdw_pkg::sdw_state_t state_r;
    sdw_pkg::sdw_state_t state_nxt;
    logic [16:0] remain_r;
    logic [47:0] cur_lba_r;
    logic [WCNT_W-1:0] word_cnt_r;
    logic bsy_r;
    logic ready_r;
    logic err_r;
    logic [7:0] error_r;
    logic hob_r;
    logic [sdw_pkg::IRQ_W-1:0] irq_stat_r;
    logic [sdw_pkg::IRQ_W-1:0] irq_mask_r;
    logic fail_load_r;
    logic [47:0] fail_lba_r;
    logic med_wvalid_r;
    logic [15:0] med_wdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so every access ends in its first access cycle
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire hit_feat = (paddr == sdw_pkg::A_FEATURE);
    wire hit_cnt = (paddr == sdw_pkg::A_SECT_CNT);
    wire hit_sn = (paddr == sdw_pkg::A_SECT_NUM);
    wire hit_cl = (paddr == sdw_pkg::A_CYL_LOW);
    wire hit_ch = (paddr == sdw_pkg::A_CYL_HIGH);
    wire hit_dh = (paddr == sdw_pkg::A_DEV_HEAD);
    wire hit_cmd = (paddr == sdw_pkg::A_CMD_STAT);
    wire hit_err = (paddr == sdw_pkg::A_ERROR);
    wire hit_dc = (paddr == sdw_pkg::A_DEV_CTL);
    wire hit_is = (paddr == sdw_pkg::A_IRQ_STAT);
    wire hit_im = (paddr == sdw_pkg::A_IRQ_MASK);
    wire hit_any = hit_feat | hit_cnt | hit_sn | hit_cl | hit_ch | hit_dh | hit_cmd
                   | hit_err | hit_dc | hit_is | hit_im;

    // task-file writes are ignored while busy so a running command keeps its inputs
    wire tf_wr_ok = apb_wr && !bsy_r;
    wire push_cnt = tf_wr_ok && hit_cnt;
    wire push_sn = tf_wr_ok && hit_sn;
    wire push_cl = tf_wr_ok && hit_cl;
    wire push_ch = tf_wr_ok && hit_ch;
    wire [7:0] wr_byte = pwdata[7:0];

    // command issue: any code starts busy; only the one code runs a transfer
    wire cmd_wr = tf_wr_ok && hit_cmd;
    wire cmd_known = (wr_byte == sdw_pkg::CMD_WRITE_DMA_EXT);

    ////////////////////////////////////////////////////////////////////////////////
    // task-file byte pairs
    wire [15:0] cnt_val;
    wire [15:0] sn_val;
    wire [15:0] cl_val;
    wire [15:0] ch_val;
    wire [7:0] cnt_rd;
    wire [7:0] sn_rd;
    wire [7:0] cl_rd;
    wire [7:0] ch_rd;

    // sector count pair: current 7:0, previous 15:8
    sdw_byte_pair u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .push(push_cnt),
        .push_byte(wr_byte),
        .load(1'b0),
        .load_val(16'h0000),
        .hob(hob_r),
        .value(cnt_val),
        .rd_byte(cnt_rd)
    );

    // lba 7:0 and 31:24
    sdw_byte_pair u_sn (
        .pclk(pclk),
        .presetn(presetn),
        .push(push_sn),
        .push_byte(wr_byte),
        .load(fail_load_r),
        .load_val({fail_lba_r[31:24], fail_lba_r[7:0]}),
        .hob(hob_r),
        .value(sn_val),
        .rd_byte(sn_rd)
    );

    // lba 15:8 and 39:32
    sdw_byte_pair u_cl (
        .pclk(pclk),
        .presetn(presetn),
        .push(push_cl),
        .push_byte(wr_byte),
        .load(fail_load_r),
        .load_val({fail_lba_r[39:32], fail_lba_r[15:8]}),
        .hob(hob_r),
        .value(cl_val),
        .rd_byte(cl_rd)
    );

    // lba 23:16 and 47:40
    sdw_byte_pair u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .push(push_ch),
        .push_byte(wr_byte),
        .load(fail_load_r),
        .load_val({fail_lba_r[47:40], fail_lba_r[23:16]}),
        .hob(hob_r),
        .value(ch_val),
        .rd_byte(ch_rd)
    );

    // start lba assembled from the pair lanes
    wire [47:0] start_lba = {ch_val[15:8], cl_val[15:8], sn_val[15:8],
                             ch_val[7:0], cl_val[7:0], sn_val[7:0]};

    // zero count stands for the full 16-bit range
    wire [16:0] start_cnt = (cnt_val == 16'h0000) ? sdw_pkg::CNT_ZERO_SECTORS
                                                  : {1'b0, cnt_val};

    ////////////////////////////////////////////////////////////////////////////////
    // transfer conditions
    wire word_take = dmarq && dmack;
    wire last_word = (word_cnt_r == LAST_WORD);
    wire sector_end = word_take && last_word;
    wire last_sector = (remain_r == 17'h00001);
    wire xfer_crc = (state_r == sdw_pkg::SDW_XFER) && link_crc_err;
    wire commit_ok = (state_r == sdw_pkg::SDW_COMMIT) && med_done && !med_fail;
    wire commit_bad = (state_r == sdw_pkg::SDW_COMMIT) && med_done && med_fail;
    wire finish = (state_r == sdw_pkg::SDW_DONE);
    wire fail_evt = commit_bad || xfer_crc;

    // dma request only while a sector is being received
    assign dmarq = (state_r == sdw_pkg::SDW_XFER) && !link_crc_err;

    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sdw_pkg::SDW_IDLE: begin
                if (cmd_wr) begin
                    state_nxt = cmd_known ? sdw_pkg::SDW_XFER : sdw_pkg::SDW_DONE;
                end
            end
            sdw_pkg::SDW_XFER: begin
                if (xfer_crc) begin
                    state_nxt = sdw_pkg::SDW_DONE;
                end else if (sector_end) begin
                    state_nxt = sdw_pkg::SDW_COMMIT;
                end
            end
            sdw_pkg::SDW_COMMIT: begin
                if (commit_bad) begin
                    state_nxt = sdw_pkg::SDW_DONE;
                end else if (commit_ok) begin
                    state_nxt = last_sector ? sdw_pkg::SDW_DONE : sdw_pkg::SDW_XFER;
                end
            end
            sdw_pkg::SDW_DONE: begin
                state_nxt = sdw_pkg::SDW_IDLE;
            end
            default: begin
                state_nxt = sdw_pkg::SDW_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sdw_pkg::SDW_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sector and word bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain_r <= 17'h00000;
            cur_lba_r <= 48'h000000000000;
        end else if (cmd_wr && cmd_known) begin
            remain_r <= start_cnt;
            cur_lba_r <= start_lba;
        end else if (commit_ok && !last_sector) begin
            remain_r <= remain_r - 17'h00001;
            cur_lba_r <= cur_lba_r + 48'h000000000001;
        end
    end

    // word counter restarts at every sector boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_cnt_r <= '0;
        end else if (cmd_wr || sector_end) begin
            word_cnt_r <= '0;
        end else if (word_take) begin
            word_cnt_r <= word_cnt_r + WCNT_W'(1);
        end
    end

    // each taken word goes straight to the media path, no buffering
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            med_wvalid_r <= 1'b0;
            med_wdata_r <= 16'h0000;
        end else begin
            med_wvalid_r <= word_take;
            if (word_take) begin
                med_wdata_r <= dma_wdata;
            end
        end
    end

    assign med_wvalid = med_wvalid_r;
    assign med_wdata = med_wdata_r;
    // commit request holds until the media answers
    assign med_req = (state_r == sdw_pkg::SDW_COMMIT);
    assign med_lba = cur_lba_r;

    ////////////////////////////////////////////////////////////////////////////////
    // failing lba is captured then loaded into the pairs one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_load_r <= 1'b0;
            fail_lba_r <= 48'h000000000000;
        end else begin
            fail_load_r <= fail_evt;
            if (fail_evt) begin
                fail_lba_r <= cur_lba_r;
            end
        end
    end

    // busy, ready/seek-complete and error status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bsy_r <= 1'b0;
            ready_r <= 1'b1;
            err_r <= 1'b0;
            error_r <= sdw_pkg::ERROR_RST;
        end else if (cmd_wr) begin
            bsy_r <= 1'b1;
            ready_r <= 1'b0;
            err_r <= !cmd_known;
            error_r <= cmd_known ? 8'h00 : (8'h01 << sdw_pkg::ER_ABT);
        end else begin
            if (finish) begin
                bsy_r <= 1'b0;
                ready_r <= 1'b1;
            end
            if (commit_bad) begin
                err_r <= 1'b1;
                error_r[sdw_pkg::ER_IDN] <= 1'b1;
            end
            if (xfer_crc) begin
                err_r <= 1'b1;
                error_r[sdw_pkg::ER_CRC] <= 1'b1;
            end
        end
    end

    // status byte; unused bits read zero
    wire [7:0] status_byte = {bsy_r, ready_r, 1'b0, ready_r, dmarq, 2'b00, err_r};

    ////////////////////////////////////////////////////////////////////////////////
    // device control, interrupt status and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hob_r <= 1'b0;
            irq_mask_r <= sdw_pkg::IRQ_RST;
        end else begin
            if (apb_wr && hit_dc) begin
                hob_r <= pwdata[sdw_pkg::DC_HOB];
            end
            if (apb_wr && hit_im) begin
                irq_mask_r <= pwdata[sdw_pkg::IRQ_W-1:0];
            end
        end
    end

    // events set once per command at the done state; set beats a same-cycle clear
    wire [sdw_pkg::IRQ_W-1:0] irq_set = {finish && err_r, finish};
    wire [sdw_pkg::IRQ_W-1:0] irq_clr = (apb_wr && hit_is) ? pwdata[sdw_pkg::IRQ_W-1:0]
                                                           : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= sdw_pkg::IRQ_RST;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // apb read mux
    wire [7:0] rd_byte = hit_cnt ? cnt_rd :
                         hit_sn ? sn_rd :
                         hit_cl ? cl_rd :
                         hit_ch ? ch_rd :
                         hit_cmd ? status_byte :
                         hit_err ? error_r :
                         hit_dc ? {hob_r, 7'h00} :
                         8'h00;
    wire [31:0] rd_word = hit_is ? {30'h00000000, irq_stat_r} :
                          hit_im ? {30'h00000000, irq_mask_r} :
                          {24'h000000, rd_byte};

    assign prdata = (psel && !pwrite && hit_any) ? rd_word : 32'h00000000;
    assign pready = 1'b1;
    // unmapped addresses fail; device/head and feature read zero, writes dropped
    assign pslverr = apb_acc && !hit_any;

endmodule : sdw_write_dma_ext

// >>> tb_top.sv
// self-checking bench for the extended dma sector write block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SW = 4;
    localparam logic [15:0] WORD0 = 16'ha5c0;
    logic pclk, presetn;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, armed = 1'b0, slow = 1'b0;
    logic link_crc_err = 1'b0, med_done = 1'b0, med_fail = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, dmarq, dmack, med_wvalid, med_req, irq, irq_q;
    logic [15:0] dma_wdata, med_wdata, exp_w = WORD0;
    logic [47:0] med_lba, base;
    int errors = 0, n_tests = 0, nword, nsect, nirq, fail_idx = -1, crc_idx = -1;

    sdw_write_dma_ext #(.SECTOR_WORDS(SW)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .dmarq, .dmack, .dma_wdata,
        .link_crc_err, .med_wvalid, .med_wdata, .med_req, .med_lba, .med_done, .med_fail,
        .irq);
    sdw_host_dma #(.WORD0(WORD0)) host (.pclk, .presetn, .armed, .slow, .dmarq, .dmack,
        .dma_wdata);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////
    // apb master: setup, then access held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            errors++;
            finish_test();
        end
    endtask : apb

    // media partner: commits one cycle after request, fails at a chosen sector
    always @(posedge pclk) begin
        if (med_wvalid === 1'b1) begin
            chk("media word", 48'(med_wdata), 48'(exp_w));
            exp_w++;
            nword++;
        end
        if (med_req === 1'b1 && med_done === 1'b1) begin
            chk("media lba", med_lba, base + 48'(nsect));
            nsect++;
        end
        nirq += int'(irq === 1'b1 && irq_q !== 1'b1);
        irq_q <= irq;
        med_done <= med_req && !med_done;
        med_fail <= nsect == fail_idx;
        link_crc_err <= dmarq && nword == crc_idx;
    end

    // one command: load count and lba, issue, await the interrupt, judge
    task automatic run_cmd(input logic [15:0] cnt, input logic [47:0] lba, input int n_sect,
                           input int n_words, input logic [7:0] err, input int fl_off);
        logic [7:0] regs [3] = '{sdw_pkg::A_SECT_NUM, sdw_pkg::A_CYL_LOW, sdw_pkg::A_CYL_HIGH};
        logic [47:0] fl;
        int i;
        nword = 0;
        nsect = 0;
        nirq = 0;
        base = lba;
        fl = lba + 48'(fl_off);
        apb(1'b1, sdw_pkg::A_SECT_CNT, 32'(cnt[15:8]));
        apb(1'b1, sdw_pkg::A_SECT_CNT, 32'(cnt[7:0]));
        for (i = 0; i < 3; i++) begin
            apb(1'b1, regs[i], 32'(lba[24 + 8 * i +: 8]));
            apb(1'b1, regs[i], 32'(lba[8 * i +: 8]));
        end
        apb(1'b1, sdw_pkg::A_IRQ_MASK, 32'h3);
        armed <= 1'b1;
        apb(1'b1, sdw_pkg::A_CMD_STAT, 32'(sdw_pkg::CMD_WRITE_DMA_EXT));
        i = 0;
        while (irq !== 1'b1 && i < 20000) begin
            @(posedge pclk);
            i++;
        end
        if (i >= 20000) begin
            errors++;
            finish_test();
        end
        armed <= 1'b0;
        if (n_words >= 0) chk("words", 48'(nword), 48'(n_words));
        chk("sectors", 48'(nsect), 48'(n_sect));
        apb(1'b0, sdw_pkg::A_CMD_STAT, 32'h0);
        chk("status", 48'(rdat[7:0]), (err != 8'h00) ? 48'h51 : 48'h50);
        apb(1'b0, sdw_pkg::A_IRQ_STAT, 32'h0);
        chk("irq status", 48'(rdat[1:0]), (err != 8'h00) ? 48'h3 : 48'h1);
        apb(1'b1, sdw_pkg::A_IRQ_STAT, 32'h3);
        apb(1'b0, sdw_pkg::A_ERROR, 32'h0);
        chk("error", 48'(rdat[7:0]), 48'(err));
        chk("irq once", 48'({irq, 8'(nirq)}), 48'h001);
        if (err != 8'h00) begin
            for (i = 0; i < 6; i++) begin
                apb(1'b1, sdw_pkg::A_DEV_CTL, (i < 3) ? 32'h0 : 32'h80);
                apb(1'b0, regs[i % 3], 32'h0);
                chk("fail lba", 48'(rdat[7:0]), 48'(fl[(i % 3) * 8 + (i / 3) * 24 +: 8]));
            end
        end
    endtask : run_cmd

    ////////////////////////////////////////
    // reset values, unmapped place and read-only feature
    task automatic t_reset();
        apb(1'b0, sdw_pkg::A_CMD_STAT, 32'h0);
        chk("reset status", 48'(rdat), 48'h50);
        apb(1'b0, sdw_pkg::A_ERROR, 32'h0);
        chk("reset error", 48'(rdat), 48'h0);
        apb(1'b1, sdw_pkg::A_FEATURE, 32'hff);
        apb(1'b0, sdw_pkg::A_FEATURE, 32'h0);
        chk("feature", 48'({rerr, rdat}), 48'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 48'(rerr), 48'h1);
        $display("test reset done");
    endtask : t_reset

    // interrupt masking around a refused command code
    task automatic t_mask();
        apb(1'b1, sdw_pkg::A_IRQ_MASK, 32'h0);
        apb(1'b1, sdw_pkg::A_CMD_STAT, 32'h30);
        apb(1'b0, sdw_pkg::A_IRQ_STAT, 32'h0);
        chk("abort irq", 48'({irq, rdat[1:0]}), 48'h3);
        apb(1'b0, sdw_pkg::A_ERROR, 32'h0);
        chk("abort err", 48'(rdat[7:0]), 48'h04);
        apb(1'b1, sdw_pkg::A_IRQ_MASK, 32'h2);
        // the write lands on the edge apb returns at; look one edge later
        @(posedge pclk);
        chk("unmasked", 48'(irq), 48'h1);
        apb(1'b1, sdw_pkg::A_IRQ_STAT, 32'h2);
        @(posedge pclk);
        chk("cleared", 48'(irq), 48'h0);
        apb(1'b1, sdw_pkg::A_IRQ_STAT, 32'h1);
        $display("test mask done");
    endtask : t_mask

    initial begin
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        run_cmd(16'h0002, 48'h0000_0000_00fe, 2, 2 * SW, 8'h00, 0);
        $display("test two sectors done");
        slow <= 1'b1;
        run_cmd(16'h0103, 48'ha1b2_c3d4_e5f6, 259, 259 * SW, 8'h00, 0);
        $display("test high count done");
        fail_idx = 2;
        run_cmd(16'h0000, 48'h0123_4567_89ff, 3, 3 * SW, 8'h10, 2);
        $display("test zero count fail done");
        fail_idx = -1;
        slow <= 1'b0;
        crc_idx = SW + 1;
        run_cmd(16'h0004, 48'h00ff_0000_0010, 1, -1, 8'h80, 1);
        $display("test crc done");
        crc_idx = -1;
        t_mask();
        finish_test();
    end
endmodule : tb_top
